// [src/asp_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic          ready;
    } asp_fifo_state_t;

    asp_fifo_state_t s_r;
    asp_fifo_state_t s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push     = inValid && s_r.ready;
    assign pop      = outValid && outReady;
    assign inReady  = s_r.ready;
    assign outValid = (s_r.count != '0);
    assign outData  = mem[s_r.rdPtr];

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.wrPtr = s_r.wrPtr + 1'b1;
        end
        if (pop)
        begin
            s_nxt.rdPtr = s_r.rdPtr + 1'b1;
        end
        if (push && !pop)
        begin
            s_nxt.count = s_r.count + 1'b1;
        end
        else if (pop && !push)
        begin
            s_nxt.count = s_r.count - 1'b1;
        end
        // Ready registered so the source sees a clean level
        s_nxt.ready = (s_nxt.count != CW'(DEPTH));
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '{wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[s_r.wrPtr] <= inData;
        end
    end
endmodule : asp_fifo
`default_nettype wire

// [src/asp_pkg.sv]
// Shared constants and types of the asynchronous serial port.
// Assumes one system clock; bit timing comes from an outside timer.
package asp_pkg;

    localparam logic [7:0] ASP_ADDR_CTRL   = 8'h98;
    localparam logic [7:0] ASP_ADDR_DATA   = 8'h99;

    localparam int         ASP_BIT_MODE    = 7;
    localparam int         ASP_BIT_FIXED   = 6;
    localparam int         ASP_BIT_MCE     = 5;
    localparam int         ASP_BIT_REN     = 4;
    localparam int         ASP_BIT_TB8     = 3;
    localparam int         ASP_BIT_RB8     = 2;
    localparam int         ASP_BIT_TI      = 1;
    localparam int         ASP_BIT_RI      = 0;

    localparam logic [7:0] ASP_CTRL_RESET  = 8'h40;
    localparam logic [7:0] ASP_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] ASP_TIMER_TOP   = 8'hFF;
    localparam logic [3:0] ASP_DATA_BITS   = 4'h8;
    localparam int         ASP_FIFO_DEPTH  = 16;
    localparam int         ASP_DATA_WIDTH  = 8;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b0_0001,
        TX_START = 5'b0_0010,
        TX_DATA  = 5'b0_0100,
        TX_NINTH = 5'b0_1000,
        TX_STOP  = 5'b1_0000
    } asp_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b0_0001,
        RX_START = 5'b0_0010,
        RX_DATA  = 5'b0_0100,
        RX_NINTH = 5'b0_1000,
        RX_STOP  = 5'b1_0000
    } asp_rx_state_t;

    // Special-function register bus request, all fields one cycle
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } asp_sfr_req_t;

    typedef struct packed {
        asp_tx_state_t txState;
        logic          txPhase;
        logic [7:0]    txShift;
        logic [3:0]    txCnt;
        logic          txPin;
        asp_rx_state_t rxState;
        logic          rxPhase;
        logic [7:0]    rxTimer;
        logic [7:0]    rxShift;
        logic [3:0]    rxCnt;
        logic          rxNinth;
        logic          rxPrev;
        logic [7:0]    ctrl;
        logic [7:0]    rxBuf;
        logic [7:0]    rdata;
        logic          irq;
    } asp_state_t;

endpackage : asp_pkg

// [src/asp_uart.sv]
// Full-duplex 8/9-bit asynchronous serial port with control and data SFRs.
// Assumes an outside 8-bit reload timer supplies its clock enable,
// run level, reload value and transmit overflow pulse.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Control bit 7 picks 8-bit framing at 0, 9-bit framing at 1.
// RQ2: 8-bit frame: start, eight data bits LSB first, stop; ten bit times.
// RQ3: 8-bit receive stores data in buffer and the stop bit as ninth bit.
// RQ4: Writing the data location starts sending that byte.
// RQ5: Transmit-done sets when the stop bit time begins.
// RQ6: Nothing is received unless the receive enable bit 4 is one.
// RQ7: 8-bit accept needs receive-done clear and, with check on, stop one.
// RQ8: A refused character touches neither buffer, ninth bit nor flag.
// RQ9: On overrun the first character stays; the later one is dropped.
// RQ10: 9-bit frame: start, eight data, ninth bit, stop; eleven bit times.
// RQ11: In 9-bit mode the sent ninth bit equals control bit 3.
// RQ12: 9-bit receive stores the ninth bit; the stop bit is ignored.
// RQ13: 9-bit accept needs receive-done clear and, with check on, ninth one.
// RQ14: Interrupt request rises, when enabled, while either done flag is set.
// RQ15: Hardware never clears the done flags; only software writes do.
// RQ16: Receive-done sets when the stop bit of an accepted frame is sampled.
// RQ17: Control bit 6 always reads one; writes to it do nothing.
// RQ18: A master sends addresses with ninth bit one, data with zero.
// RQ19: With check on in 9-bit mode, only ninth-bit-one frames interrupt.
// RQ20: Bit rate is half the timer overflow rate; reload sets the period.
// RQ21: Receive timer copies the reload and restarts on a start edge.
// RQ22: Data writes go to transmit, reads return the receive buffer.
// RQ23: Start found on a falling edge; bits sampled mid-period.
module asp_uart
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire asp_sfr_req_t sfrReq,
    output logic [7:0]        sfrRdata,
    input  wire logic         timerRun,
    input  wire logic         timerTick,
    input  wire logic [7:0]   baudReloadValue,
    input  wire logic         txTimerOvf,
    input  wire logic         irqEnable,
    input  wire logic         serialInPin,
    output logic              serialOutPin,
    output logic              uartIrq,
    output logic              txBufReady
);
    asp_state_t       s_r;
    asp_state_t       s_nxt;
    logic             fifoInValid;
    logic             fifoOutValid;
    logic [7:0]       fifoOutData;
    logic             fifoPop;
    logic             txBoundary;
    logic             rxOvf;
    logic             rxSample;
    logic             ninthVal;
    logic             mode9;

    // RQ22: data writes feed transmit
    assign fifoInValid = sfrReq.wr && (sfrReq.addr == ASP_ADDR_DATA);
    // RQ1: mode bit picks framing
    assign mode9       = s_r.ctrl[ASP_BIT_MODE];
    // RQ20: divide transmit overflows by two
    assign txBoundary  = txTimerOvf && s_r.txPhase;

    assign sfrRdata     = s_r.rdata;
    assign serialOutPin = s_r.txPin;
    assign uartIrq      = s_r.irq;

    asp_fifo #(
        .WIDTH (ASP_DATA_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_txFifo (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .inValid  (fifoInValid),
        .inData   (sfrReq.wdata),
        .inReady  (txBufReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoPop)
    );

    always_comb
    begin
        s_nxt    = s_r;
        fifoPop  = 1'b0;
        rxOvf    = 1'b0;
        rxSample = 1'b0;
        ninthVal = 1'b0;

        // Software writes first so hardware sets below win
        if (sfrReq.wr && (sfrReq.addr == ASP_ADDR_CTRL))
        begin
            s_nxt.ctrl = sfrReq.wdata;
        end
        // RQ17: fixed bit reads one
        s_nxt.ctrl[ASP_BIT_FIXED] = 1'b1;

        if (sfrReq.rd)
        begin
            if (sfrReq.addr == ASP_ADDR_CTRL)
            begin
                s_nxt.rdata = s_r.ctrl;
            end
            // RQ22: reads return receive buffer
            else if (sfrReq.addr == ASP_ADDR_DATA)
            begin
                s_nxt.rdata = s_r.rxBuf;
            end
            else
            begin
                s_nxt.rdata = ASP_BYTE_ZERO;
            end
        end

        // Transmitter
        if (txTimerOvf)
        begin
            s_nxt.txPhase = !s_r.txPhase;
        end
        if (txBoundary)
        begin
            case (s_r.txState)
                TX_START:
                begin
                    s_nxt.txPin   = s_r.txShift[0];
                    s_nxt.txShift = s_r.txShift >> 1;
                    s_nxt.txCnt   = 4'h1;
                    s_nxt.txState = TX_DATA;
                end
                TX_DATA:
                begin
                    // RQ2: LSB-first data bits
                    if (s_r.txCnt == ASP_DATA_BITS)
                    begin
                        if (mode9)
                        begin
                            // RQ11: ninth bit from control
                            s_nxt.txPin   = s_r.ctrl[ASP_BIT_TB8];
                            s_nxt.txState = TX_NINTH;
                        end
                        else
                        begin
                            // RQ5: done at stop start
                            s_nxt.txPin             = 1'b1;
                            s_nxt.ctrl[ASP_BIT_TI]  = 1'b1;
                            s_nxt.txState           = TX_STOP;
                        end
                    end
                    else
                    begin
                        s_nxt.txPin   = s_r.txShift[0];
                        s_nxt.txShift = s_r.txShift >> 1;
                        s_nxt.txCnt   = s_r.txCnt + 4'h1;
                    end
                end
                TX_NINTH:
                begin
                    // RQ10: stop after the ninth bit
                    s_nxt.txPin            = 1'b1;
                    s_nxt.ctrl[ASP_BIT_TI] = 1'b1;
                    s_nxt.txState          = TX_STOP;
                end
                default:
                begin
                    // RQ4: queued byte starts a frame
                    s_nxt.txState = TX_IDLE;
                    s_nxt.txPin   = 1'b1;
                    if (fifoOutValid)
                    begin
                        fifoPop       = 1'b1;
                        s_nxt.txShift = fifoOutData;
                        s_nxt.txPin   = 1'b0;
                        s_nxt.txState = TX_START;
                    end
                end
            endcase
        end

        // RQ21: private receive timer, same reload
        if (timerRun && timerTick)
        begin
            if (s_r.rxTimer == ASP_TIMER_TOP)
            begin
                s_nxt.rxTimer = baudReloadValue;
                rxOvf         = 1'b1;
            end
            else
            begin
                s_nxt.rxTimer = s_r.rxTimer + 8'h01;
            end
        end
        // RQ23: sample on first overflow of each pair
        if (rxOvf)
        begin
            s_nxt.rxPhase = !s_r.rxPhase;
            rxSample      = !s_r.rxPhase;
        end

        s_nxt.rxPrev = serialInPin;
        case (s_r.rxState)
            RX_START:
            begin
                if (rxSample)
                begin
                    // Glitch shorter than half a bit is rejected
                    s_nxt.rxState = serialInPin ? RX_IDLE : RX_DATA;
                    s_nxt.rxCnt   = 4'h0;
                end
            end
            RX_DATA:
            begin
                if (rxSample)
                begin
                    s_nxt.rxShift = {serialInPin, s_r.rxShift[7:1]};
                    s_nxt.rxCnt   = s_r.rxCnt + 4'h1;
                    if (s_r.rxCnt == ASP_DATA_BITS - 4'h1)
                    begin
                        s_nxt.rxState = mode9 ? RX_NINTH : RX_STOP;
                    end
                end
            end
            RX_NINTH:
            begin
                if (rxSample)
                begin
                    s_nxt.rxNinth = serialInPin;
                    s_nxt.rxState = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (rxSample)
                begin
                    // RQ3: stop bit as ninth in 8-bit mode
                    // RQ12: stored ninth bit in 9-bit mode
                    ninthVal      = mode9 ? s_r.rxNinth : serialInPin;
                    s_nxt.rxState = RX_IDLE;
                    // RQ7: accept checks, RQ13 and RQ19 alike
                    // RQ9: full buffer drops the new frame
                    // RQ8: refused frame changes nothing
                    if (!s_r.ctrl[ASP_BIT_RI] &&
                        (!s_r.ctrl[ASP_BIT_MCE] || ninthVal))
                    begin
                        // RQ16: done flag at stop sample
                        s_nxt.rxBuf             = s_r.rxShift;
                        s_nxt.ctrl[ASP_BIT_RB8] = ninthVal;
                        s_nxt.ctrl[ASP_BIT_RI]  = 1'b1;
                    end
                end
            end
            default:
            begin
                // RQ6: start only while enabled
                if (s_r.ctrl[ASP_BIT_REN] && s_r.rxPrev && !serialInPin)
                begin
                    // RQ21: forced reload on start
                    s_nxt.rxTimer = baudReloadValue;
                    s_nxt.rxPhase = 1'b0;
                    s_nxt.rxState = RX_START;
                end
            end
        endcase

        // RQ14: request while a done flag is set
        // RQ15: flags leave only by software write
        s_nxt.irq = irqEnable &&
                    (s_nxt.ctrl[ASP_BIT_TI] || s_nxt.ctrl[ASP_BIT_RI]);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '{txState: TX_IDLE, txPhase: 1'b0,
                     txShift: ASP_BYTE_ZERO, txCnt: 4'h0, txPin: 1'b1,
                     rxState: RX_IDLE, rxPhase: 1'b0,
                     rxTimer: ASP_BYTE_ZERO, rxShift: ASP_BYTE_ZERO,
                     rxCnt: 4'h0, rxNinth: 1'b0, rxPrev: 1'b1,
                     ctrl: ASP_CTRL_RESET, rxBuf: ASP_BYTE_ZERO,
                     rdata: ASP_BYTE_ZERO, irq: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule : asp_uart
`default_nettype wire

// [tb/asp_remote_node.sv]
// Remote serial node: sends frames and captures what it hears.
// Assumes idle-high lines and a fixed bit length in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module asp_remote_node #(
    parameter int BIT = 8
) (
    input  wire logic ref_clk,
    input  wire logic lineIn,
    input  wire logic nineMode,
    output logic      lineOut
);
    logic [9:0]  gotQ[$];
    logic [10:0] shift;
    initial lineOut = 1'b1;
    // start, data LSB first, ninth in nine mode only, stop
    task automatic send(input logic [7:0] d, input logic nb,
                        input logic sv);
        logic [10:0] f;
        f = nineMode ? {sv, nb, d, 1'b0} : {1'b1, sv, d, 1'b0};
        for (int i = 0; i < (nineMode ? 11 : 10); i++)
        begin
            @(posedge ref_clk);
            lineOut <= f[i];
            repeat (BIT - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        lineOut <= 1'b1;
        repeat (2 * BIT) @(posedge ref_clk);
    endtask
    // mid-bit capture, stored as stop, ninth, data
    initial forever
    begin
        @(posedge ref_clk);
        if (lineIn === 1'b0)
        begin
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < (nineMode ? 10 : 9); i++)
            begin
                repeat (BIT) @(posedge ref_clk);
                shift[i] = lineIn;
            end
            gotQ.push_back(nineMode ? shift[9:0] : {shift[8], shift[8:0]});
        end
    end
endmodule // asp_remote_node
`default_nettype wire

// [tb/asp_uart_props.sv]
// Assertion checker for the serial port top module.
// Assumes one clock domain; bound to every asp_uart instance.
`timescale 1ns/1ps
`default_nettype none
module asp_uart_props
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
    input wire logic         ref_clk,
    input wire logic         arst_n,
    input wire asp_sfr_req_t sfrReq,
    input wire logic [7:0]   sfrRdata,
    input wire logic         timerRun,
    input wire logic         timerTick,
    input wire logic [7:0]   baudReloadValue,
    input wire logic         txTimerOvf,
    input wire logic         irqEnable,
    input wire logic         serialInPin,
    input wire logic         serialOutPin,
    input wire logic         uartIrq,
    input wire logic         txBufReady
);
    logic outPrev_r;
    logic ovfOdd_r;
    logic ctrlWr_r;
    logic ctrlWr;
    assign ctrlWr = sfrReq.wr && sfrReq.addr == ASP_ADDR_CTRL;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Overflow parity since the last line change
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outPrev_r <= 1'b1;
            ovfOdd_r  <= 1'b0;
            ctrlWr_r  <= 1'b0;
        end
        else
        begin
            outPrev_r <= serialOutPin;
            ovfOdd_r  <= (serialOutPin != outPrev_r) ? txTimerOvf
                                                     : ovfOdd_r ^ txTimerOvf;
            ctrlWr_r  <= ctrlWr;
        end
    end
    a_fixed_bit_one: assert property (
        sfrReq.rd && sfrReq.addr == ASP_ADDR_CTRL |=> sfrRdata[6])
        else $error("control read without fixed bit");
    a_unmapped_read: assert property (
        sfrReq.rd && sfrReq.addr != ASP_ADDR_CTRL
        && sfrReq.addr != ASP_ADDR_DATA |=> sfrRdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_held: assert property (
        !sfrReq.rd |=> $stable(sfrRdata))
        else $error("read data moved without read");
    a_irq_gated: assert property (!irqEnable |=> !uartIrq)
        else $error("interrupt while disabled");
    // Write in either cycle may clear a flag legally
    a_flags_sticky: assert property (
        uartIrq && irqEnable && !ctrlWr && !ctrlWr_r |=> uartIrq)
        else $error("done flag dropped without write");
    a_reset_idle: assert property (
        disable iff (1'b0) !arst_n |-> serialOutPin && !uartIrq
        && txBufReady && sfrRdata == 8'h00)
        else $error("outputs not idle in reset");
    a_bit_on_ovf: assert property (
        $changed(serialOutPin) |-> $past(txTimerOvf) || $past(txTimerOvf, 2))
        else $error("serial output moved off a boundary");
    a_two_ovf_bit: assert property (
        serialOutPin != outPrev_r |-> !ovfOdd_r)
        else $error("bit not two overflows long");
    c_tx_start: cover property ($fell(serialOutPin));
    c_irq: cover property ($rose(uartIrq));
    c_full: cover property (!txBufReady);
endmodule // asp_uart_props
bind asp_uart asp_uart_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .timerRun(timerRun), .timerTick(timerTick),
    .baudReloadValue(baudReloadValue), .txTimerOvf(txTimerOvf),
    .irqEnable(irqEnable), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .uartIrq(uartIrq),
    .txBufReady(txBufReady));
`default_nettype wire

// [tb/asp_uart_tb.sv]
// Self-checking bench: registers, both directions, transmit queue.
// Assumes the remote node model and the bound assertion checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
    numErrors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module asp_uart_tb
    import asp_pkg::*;
;
    localparam int BIT = 8;
    typedef struct packed {
        logic       w;
        logic [7:0] c;
        logic [7:0] d;
        logic       n;
        logic       s;
        logic [7:0] ec;
        logic [7:0] ed;
    } asp_rx_case_t;
    logic         ref_clk = 1'b0;
    logic         arst_n = 1'b1;
    asp_sfr_req_t sfrReq = '0;
    logic         txTimerOvf = 1'b0;
    logic         irqEnable = 1'b0;
    logic         nine = 1'b0;
    logic [1:0]   ovfDiv = 2'h0;
    logic [7:0]   sfrRdata;
    logic [7:0]   rv;
    logic         serialInPin;
    logic         serialOutPin;
    logic         uartIrq;
    logic         txBufReady;
    int           numErrors = 0;
    int           samplesChecked = 0;
    int           cyc = 0;
    int           n;
    asp_rx_case_t cases[8] = '{
        '{1'b1, 8'h00, 8'h5A, 1'b1, 1'b1, 8'h40, 8'h00},
        '{1'b1, 8'h10, 8'h5A, 1'b0, 1'b1, 8'h55, 8'h5A},
        '{1'b0, 8'h00, 8'h11, 1'b0, 1'b1, 8'h55, 8'h5A},
        '{1'b1, 8'h30, 8'h77, 1'b0, 1'b0, 8'h70, 8'h5A},
        '{1'b0, 8'h00, 8'h66, 1'b0, 1'b1, 8'h75, 8'h66},
        '{1'b1, 8'hB0, 8'h42, 1'b0, 1'b1, 8'hF0, 8'h66},
        '{1'b0, 8'h00, 8'h43, 1'b1, 1'b1, 8'hF5, 8'h43},
        '{1'b1, 8'h90, 8'h24, 1'b0, 1'b0, 8'hD1, 8'h24}};
    always #2.5 ref_clk = ~ref_clk;
    // Overflow every fourth clock, so a bit is eight clocks
    always @(posedge ref_clk)
    begin
        ovfDiv <= ovfDiv + 2'h1;
        txTimerOvf <= (ovfDiv == 2'h3);
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            numErrors++;
            closeOut();
        end
    end
    asp_uart #(.FIFO_DEPTH(4)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata), .timerRun(1'b1), .timerTick(1'b1),
        .baudReloadValue(8'hFC), .txTimerOvf(txTimerOvf),
        .irqEnable(irqEnable), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .uartIrq(uartIrq),
        .txBufReady(txBufReady));
    asp_remote_node #(.BIT(BIT)) peer (
        .ref_clk(ref_clk), .lineIn(serialOutPin), .nineMode(nine),
        .lineOut(serialInPin));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrReq <= '{a, 1'b1, 1'b0, d};
        @(posedge ref_clk);
        sfrReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfrReq <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge ref_clk);
        sfrReq <= '0;
        #1 d = sfrRdata;
    endtask
    task automatic expectFrame(input logic [9:0] e);
        logic [9:0] g = 'x;
        for (int i = 0; i < 400 && peer.gotQ.size() == 0; i++)
            @(posedge ref_clk);
        if (peer.gotQ.size() != 0)
            g = peer.gotQ.pop_front();
        `CHK("frame", e, g)
    endtask
    task automatic closeOut();
        $display("Checks %0d, errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(ASP_ADDR_CTRL, rv);
        `CHK("ctrl reset", 8'h40, rv)
        wr(ASP_ADDR_CTRL, 8'h00);
        rd(ASP_ADDR_CTRL, rv);
        `CHK("ctrl bit6", 8'h40, rv)
        rd(8'h50, rv);
        `CHK("unmapped", 8'h00, rv)
        $display("Test registers done");
        @(posedge ref_clk);
        irqEnable <= 1'b1;
        wr(ASP_ADDR_DATA, 8'hA5);
        expectFrame(10'h3A5);
        rd(ASP_ADDR_CTRL, rv);
        `CHK("tx done", 8'h42, rv)
        `CHK("irq on", 1'b1, uartIrq)
        @(posedge ref_clk);
        irqEnable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 `CHK("irq off", 1'b0, uartIrq)
        for (int t = 0; t < 2; t++)
        begin
            wr(ASP_ADDR_CTRL, t ? 8'h88 : 8'h80);
            nine <= 1'b1;
            wr(ASP_ADDR_DATA, 8'h3C + 8'(t));
            expectFrame({1'b1, t[0], 8'h3C + 8'(t)});
        end
        $display("Test transmit done");
        foreach (cases[i])
        begin
            if (cases[i].w)
            begin
                wr(ASP_ADDR_CTRL, cases[i].c);
                // Blocking, so the peer frames this case in the new mode
                nine = cases[i].c[7];
            end
            peer.send(cases[i].d, cases[i].n, cases[i].s);
            rd(ASP_ADDR_CTRL, rv);
            `CHK("rx ctrl", cases[i].ec, rv)
            rd(ASP_ADDR_DATA, rv);
            `CHK("rx data", cases[i].ed, rv)
        end
        $display("Test receive done");
        wr(ASP_ADDR_CTRL, 8'h00);
        nine <= 1'b0;
        wr(ASP_ADDR_DATA, 8'h10);
        n = 1;
        // Fill after the first pop, so the queue stays full for the drop
        while (serialOutPin !== 1'b0)
            @(posedge ref_clk);
        while (n < 20)
        begin
            #1;
            if (txBufReady !== 1'b1)
                break;
            wr(ASP_ADDR_DATA, 8'h10 + 8'(n));
            n++;
        end
        // Depth of four plus the byte already in the shifter
        `CHK("fill", 5, n)
        wr(ASP_ADDR_DATA, 8'hEE);
        for (int i = 0; i < n; i++)
            expectFrame({2'h3, 8'h10 + 8'(i)});
        repeat (40 * BIT) @(posedge ref_clk);
        `CHK("dropped", 0, peer.gotQ.size())
        `CHK("drained", 1'b1, txBufReady)
        $display("Test queue done");
        closeOut();
    end
endmodule // asp_uart_tb
`default_nettype wire
